// [icx_checker.sv]
// Checker: port-level properties of the interrupt block
`timescale 1ns/100ps
module icx_checker import icx_pkg::*; #(
  parameter int unsigned PC_W = 13 // Program counter width
) (
  input wire logic ref_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pslverr, // APB error
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] prdata, // APB read data
  input wire icx_evt_s src_evt, // Source event pulses
  input wire logic cpu_boundary, // Core may accept a vector
  input wire logic stack_full, // Stack has no room
  input wire logic return_from_interrupt_exec, // Return executed
  input wire logic irq_take, // Vector taken
  input wire logic stack_push, // Push request
  input wire logic stack_pop, // Pop request
  input wire logic pc_load, // Load PC
  input wire logic wake, // Wake pulse
  input wire logic [PC_W-1:0] pc_next, // Next instruction address
  input wire logic [PC_W-1:0] stack_top, // Saved PC on top
  input wire logic [PC_W-1:0] irq_vector, // Vector address
  input wire logic [PC_W-1:0] push_addr, // Value pushed
  input wire logic [PC_W-1:0] pc_load_addr // Returned PC
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_take_push: assert property (
    irq_take |-> stack_push && push_addr == $past(pc_next))
    else $error("push missing at take");
  a_take_cause: assert property (
    irq_take |-> $past(cpu_boundary) && !$past(stack_full))
    else $error("take without boundary or with full stack");
  a_no_nest: assert property (
    irq_take |=> !irq_take)
    else $error("second take without re-enable");
  a_vector_held: assert property (
    !irq_take |-> $stable(irq_vector))
    else $error("vector moved without take");
  a_pop_cause: assert property (
    stack_pop |-> pc_load && $past(return_from_interrupt_exec) &&
      pc_load_addr == $past(stack_top))
    else $error("pop without return or wrong address");
  a_return_from_interrupt_pop: assert property (
    return_from_interrupt_exec && stack_full |=> stack_pop)
    else $error("return not popped");
  a_wake_evt: assert property (
    src_evt != '0 |=> wake)
    else $error("no wake after event");
  a_bad_addr: assert property (
    psel && penable |->
      pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h20))
    else $error("error response wrong");
  c_take: cover property (irq_take);
  c_pop: cover property (stack_pop);
  c_wake: cover property (wake);
endmodule

bind icx_top icx_checker #(.PC_W(PC_W)) icx_checker_i (
  .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pslverr(pslverr), .paddr(paddr), .prdata(prdata), .src_evt(src_evt),
  .cpu_boundary(cpu_boundary), .stack_full(stack_full),
  .return_from_interrupt_exec(return_from_interrupt_exec), .irq_take(irq_take), .stack_push(stack_push),
  .stack_pop(stack_pop), .pc_load(pc_load), .wake(wake),
  .pc_next(pc_next), .stack_top(stack_top), .irq_vector(irq_vector),
  .push_addr(push_addr), .pc_load_addr(pc_load_addr));

// [icx_cpu_model.sv]
// Core model: program sequencer and two-deep return stack
`timescale 1ns/100ps
module icx_cpu_model #(
  parameter int unsigned PC_W = 13, // Program counter width
  parameter int unsigned DEPTH = 2 // Stack levels
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic run, // Accept vectors
  input wire logic ret, // Execute a return
  input wire logic stack_push, // Push request
  input wire logic stack_pop, // Pop request
  input wire logic irq_take, // Vector taken
  input wire logic [PC_W-1:0] push_addr, // Value to push
  input wire logic [PC_W-1:0] irq_vector, // Vector address
  output logic cpu_boundary, // Boundary reached
  output logic stack_full, // No room left
  output logic return_from_interrupt_exec, // Return executed
  output logic [PC_W-1:0] pc_next, // Next instruction address
  output logic [PC_W-1:0] stack_top // Saved PC on top
);
  logic [PC_W-1:0] mem_q [DEPTH];
  int unsigned sp_q;
  assign cpu_boundary = run;
  assign return_from_interrupt_exec = ret;
  assign stack_full = (sp_q == DEPTH);
  // Empty stack shows a changing pattern, not a stale entry
  assign stack_top = (sp_q == 0) ? ~pc_next : mem_q[sp_q-1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= 0;
      pc_next <= '0;
    end else begin
      pc_next <= irq_take ? irq_vector + 1'b1 : pc_next + 1'b1;
      if (stack_push && sp_q < DEPTH) begin
        mem_q[sp_q] <= push_addr;
        sp_q <= sp_q + 1;
      end else if (stack_pop && sp_q > 0) begin
        sp_q <= sp_q - 1;
      end
    end
  end
endmodule

// [icx_pkg.sv]
// Package: register map, field positions and types of the interrupt block
package icx_pkg;
  localparam int unsigned NREG = 9;
  localparam int unsigned NSRC = 11;
  localparam logic [7:0] OFS_EDGE = 8'h00;
  localparam logic [7:0] OFS_STEP = 8'h04;
  localparam int unsigned R_EDGE = 0;
  localparam int unsigned R_CTL0 = 1;
  localparam int unsigned R_GRP = 2;
  localparam int unsigned R_CTL2 = 3;
  localparam int unsigned R_IRQ_TIMER0_GROUP = 4;
  localparam int unsigned R_IRQ_SERIAL_MEM_LVD_GROUP = 8;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [7:0] MASK_EDGE = 8'h0F;
  localparam logic [7:0] MASK_CTL0 = 8'h7F;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_TMR = 8'h33;
  localparam logic [7:0] MASK_TMR3 = 8'h77;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam int unsigned B_GIE = 0;
  localparam int unsigned B_EXT0_F = 4;
  localparam int unsigned B_CMP_F = 5;
  localparam int unsigned B_GRP0_F = 6;
  localparam int unsigned B_GRP0_E = 3;
  localparam int unsigned B_FLAG_LO = 4;
  localparam logic [1:0] EDGE_OFF = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  // Priority order, index 0 highest
  typedef enum logic [3:0] {
    SRC_EXT0, SRC_CMP, SRC_GRP0, SRC_GRP1, SRC_GRP2, SRC_GRP3, SRC_GRP4,
    SRC_ADC, SRC_TICK0, SRC_TICK1, SRC_EXT1
  } icx_src_e;
  localparam int unsigned FLAG_REG [NSRC] =
    '{1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3};
  localparam int unsigned FLAG_BIT [NSRC] =
    '{4, 5, 6, 4, 5, 6, 7, 4, 5, 6, 7};
  localparam int unsigned EN_BIT [NSRC] =
    '{1, 2, 3, 0, 1, 2, 3, 0, 1, 2, 3};
  typedef struct packed {
    logic [3:0] tmr_cmpp;
    logic [3:0] tmr_cmpa;
    logic tmr3_cmpb;
    logic [3:0] periph;
    logic cmp;
    logic adc;
    logic tick0;
    logic tick1;
  } icx_evt_s;
endpackage

// [icx_top.sv]
// Interrupt controller: flags, enables, priority, vectoring, APB registers
`timescale 1ns/100ps
// What this block does
// - Group enables for groups 4 to 1 sit in bits 3 to 0.
// - Control register 2 bits 7..4: ext1, tick1, tick0, adc flags.
// - Same register bits 3..0 enable them; all bits RW, reset 0.
// - Timer0 group: cmpA flag bit5, period bit4, enables bits 1,0.
// - Timer1 group, larger variants: same layout, reset zero.
// - Timer2 group: same layout as timer0.
// - Timer3 group: B,A,period flags bits 6..4, enables bits 2..0.
// - Serial group: spi, serial, eeprom, low-volt flags 7..4, enables 3..0.
// - A source event sets its flag regardless of its enable.
// - Vector only when the source enable is set; flag stays.
// - Global enable low blocks every interrupt.
// - Taking an interrupt pushes next PC and loads the vector.
// - Return from interrupt pops the saved PC, except in a cycle that also takes a vector.
// - Service clears global enable; new requests still latch.
// - Stack full holds off acknowledge until it drains.
// - Simultaneous requests served by fixed priority.
// - Any flag becoming set wakes from sleep or idle.
// - Ext pin flag set on edge chosen by its edge select.
// - Ext pin service clears its flag and global enable.
// - Ext input 1 is driven by the radio interrupt output.
// - Edge select: 00 off, 01 rise, 10 fall, 11 both.
// - Group service clears the group flag and global enable, not member flags.
module icx_top import icx_pkg::*; #(
  parameter int unsigned PC_W = 13, // Program counter width
  parameter logic [12:0] VEC_BASE = 13'h0004, // First vector
  parameter logic [12:0] VEC_STEP = 13'h0004, // Vector spacing
  parameter bit HAS_TMR1 = 1'b1 // Timer1 group present
) (
  input wire logic ref_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic ext_irq_pin0, // External pin 0
  input wire logic rf_irq, // Radio interrupt output
  input wire icx_evt_s src_evt, // Source event pulses
  input wire logic cpu_boundary, // Core may accept a vector
  input wire logic stack_full, // Stack has no room
  input wire logic [PC_W-1:0] pc_next, // Address of next instruction
  input wire logic return_from_interrupt_exec, // Return from interrupt executed
  input wire logic [PC_W-1:0] stack_top, // Saved PC on top of stack
  output logic irq_take, // Vector taken, pulse
  output logic [PC_W-1:0] irq_vector, // Vector address to load
  output logic stack_push, // Push request, pulse
  output logic [PC_W-1:0] push_addr, // Value to push
  output logic stack_pop, // Pop request, pulse
  output logic pc_load, // Load PC from pc_load_addr
  output logic [PC_W-1:0] pc_load_addr, // Returned PC
  output logic wake // Wake from sleep, pulse
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_prev_q;
  logic [1:0] pin_raw;
  logic [1:0] pin_edge;
  logic [7:0] reg_q [NREG];
  assign pin_raw = {rf_irq, ext_irq_pin0};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 2'b00;
      pin_s2_q <= 2'b00;
      pin_prev_q <= 2'b00;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end
  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      wire [1:0] sel = reg_q[R_EDGE][2*p+1 -: 2];
      wire rise = pin_s2_q[p] & ~pin_prev_q[p];
      wire fall = ~pin_s2_q[p] & pin_prev_q[p];
      assign pin_edge[p] = ((sel == EDGE_RISE) & rise)
        | ((sel == EDGE_FALL) & fall)
        | ((sel == EDGE_BOTH) & (rise | fall));
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [7:0] idx_w = (paddr - OFS_EDGE) >> 2;
  wire [3:0] reg_idx = idx_w[3:0];
  wire addr_ok = (paddr[1:0] == 2'b00) && (idx_w < NREG);
  wire acc_wr = psel & penable & pwrite & addr_ok;
  wire setup_rd = psel & ~penable & ~pwrite & addr_ok;
  logic [31:0] prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_q <= {24'h00_0000, reg_q[reg_idx]};
    end else if (psel & ~penable) begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Implemented-bit masks
  // ----------------------------------------------------------------
  logic [7:0] reg_mask [NREG];
  assign reg_mask[R_EDGE] = MASK_EDGE;
  assign reg_mask[R_CTL0] = MASK_CTL0;
  assign reg_mask[R_GRP] = MASK_FULL;
  assign reg_mask[R_CTL2] = MASK_FULL;
  assign reg_mask[R_IRQ_TIMER0_GROUP] = MASK_TMR;
  assign reg_mask[R_IRQ_TIMER0_GROUP+1] = HAS_TMR1 ? MASK_TMR : MASK_NONE;
  assign reg_mask[R_IRQ_TIMER0_GROUP+2] = MASK_TMR;
  assign reg_mask[R_IRQ_TIMER0_GROUP+3] = MASK_TMR3;
  assign reg_mask[R_IRQ_SERIAL_MEM_LVD_GROUP] = MASK_FULL;

  // ----------------------------------------------------------------
  // Source flag setting
  // ----------------------------------------------------------------
  logic [3:0] mfi_set [5];
  logic [4:0] grp_any;
  logic [4:0] grp_any_q;
  logic [4:0] grp_rise;
  assign mfi_set[0] = {2'b00, src_evt.tmr_cmpa[0], src_evt.tmr_cmpp[0]};
  assign mfi_set[1] = {2'b00, src_evt.tmr_cmpa[1], src_evt.tmr_cmpp[1]};
  assign mfi_set[2] = {2'b00, src_evt.tmr_cmpa[2], src_evt.tmr_cmpp[2]};
  assign mfi_set[3] = {1'b0, src_evt.tmr3_cmpb, src_evt.tmr_cmpa[3],
    src_evt.tmr_cmpp[3]};
  assign mfi_set[4] = src_evt.periph;
  generate
    for (genvar g = 0; g < 5; g++) begin : g_grp
      wire [7:0] r = reg_q[R_IRQ_TIMER0_GROUP+g];
      assign grp_any[g] = |(r[7:4] & r[3:0]);
    end
  endgenerate
  assign grp_rise = grp_any & ~grp_any_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      grp_any_q <= 5'b00000;
    end else begin
      grp_any_q <= grp_any;
    end
  end

  // ----------------------------------------------------------------
  // Pending requests and priority
  // ----------------------------------------------------------------
  logic [NSRC-1:0] pend;
  logic any_pend;
  logic [3:0] win;
  generate
    for (genvar s = 0; s < NSRC; s++) begin : g_pend
      assign pend[s] = reg_q[FLAG_REG[s]][FLAG_BIT[s]]
        & reg_q[FLAG_REG[s]][EN_BIT[s]];
    end
  endgenerate
  always_comb begin
    win = 4'h0;
    any_pend = 1'b0;
    for (int s = NSRC - 1; s >= 0; s--) begin
      if (pend[s]) begin
        win = 4'(s);
        any_pend = 1'b1;
      end
    end
  end
  wire gie = reg_q[R_CTL0][B_GIE];
  wire take = cpu_boundary & gie & any_pend & ~stack_full;

  // ----------------------------------------------------------------
  // Hardware set and clear per register
  // ----------------------------------------------------------------
  logic [7:0] hw_set [NREG];
  logic [7:0] hw_clr [NREG];
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      hw_set[i] = 8'h00;
      hw_clr[i] = 8'h00;
    end
    hw_set[R_CTL0][B_EXT0_F] = pin_edge[0];
    hw_set[R_CTL0][B_CMP_F] = src_evt.cmp;
    hw_set[R_CTL0][B_GRP0_F] = grp_rise[0];
    hw_set[R_GRP][7:4] = grp_rise[4:1];
    hw_set[R_CTL2][7:4] = {pin_edge[1], src_evt.tick1, src_evt.tick0,
      src_evt.adc};
    for (int g = 0; g < 5; g++) begin
      hw_set[R_IRQ_TIMER0_GROUP+g][7:4] = mfi_set[g];
    end
    if (take) begin
      hw_clr[R_CTL0][B_GIE] = 1'b1;
      hw_clr[FLAG_REG[win]][FLAG_BIT[win]] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register storage, hardware set wins over any clear
  // ----------------------------------------------------------------
  logic [NREG-1:0] any_set;
  generate
    for (genvar i = 0; i < NREG; i++) begin : g_reg
      logic [7:0] reg_d;
      logic [7:0] base;
      assign base = (acc_wr && reg_idx == 4'(i)) ? pwdata[7:0] : reg_q[i];
      assign reg_d = ((base & ~hw_clr[i]) | hw_set[i]) & reg_mask[i];
      assign any_set[i] = |(hw_set[i] & reg_mask[i]);
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          reg_q[i] <= RST_VAL;
        end else begin
          reg_q[i] <= reg_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Core side: vectoring, return and wake
  // ----------------------------------------------------------------
  logic take_q;
  logic [PC_W-1:0] vec_q;
  logic [PC_W-1:0] push_q;
  logic return_from_interrupt_q;
  logic [PC_W-1:0] ret_q;
  logic wake_q;
  wire [PC_W-1:0] vec_d = PC_W'(VEC_BASE + VEC_STEP * 13'(win));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      take_q <= 1'b0;
      vec_q <= '0;
      push_q <= '0;
      return_from_interrupt_q <= 1'b0;
      ret_q <= '0;
      wake_q <= 1'b0;
    end else begin
      take_q <= take;
      if (take) begin
        vec_q <= vec_d;
        push_q <= pc_next;
      end
      return_from_interrupt_q <= return_from_interrupt_exec & ~take;
      if (return_from_interrupt_exec) begin
        ret_q <= stack_top;
      end
      wake_q <= |any_set;
    end
  end
  assign irq_take = take_q;
  assign irq_vector = vec_q;
  assign stack_push = take_q;
  assign push_addr = push_q;
  assign stack_pop = return_from_interrupt_q;
  assign pc_load = return_from_interrupt_q;
  assign pc_load_addr = ret_q;
  assign wake = wake_q;
endmodule

// [tb_icx_top.sv]
// Testbench: registers, events, vectoring, return and pin edges
`timescale 1ns/100ps
module tb_icx_top import icx_pkg::*;;
  logic ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, ext0 = 0, rf = 0, run = 0, ret = 0;
  icx_evt_s evt = '0;
  logic full, return_from_interrupt, push, pop, take, pcl, wake, bnd;
  logic [12:0] pcn, top, vec, pa, pla, lv;
  logic [7:0] msk [NREG] = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'h33,
    8'h33, 8'h77, 8'hFF};
  int errors = 0, tests_run = 0, nt = 0, tn = 0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (take === 1'b1) begin
    nt++;
    lv = vec;
  end
  icx_top icx_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin0(ext0), .rf_irq(rf), .src_evt(evt), .cpu_boundary(bnd),
    .stack_full(full), .pc_next(pcn), .return_from_interrupt_exec(return_from_interrupt), .stack_top(top),
    .irq_take(take), .irq_vector(vec), .stack_push(push), .push_addr(pa),
    .stack_pop(pop), .pc_load(pcl), .pc_load_addr(pla), .wake(wake));
  icx_cpu_model icx_cpu_model_i (.clk(ref_clk), .rst_n(arst_n), .run(run),
    .ret(ret), .stack_push(push), .stack_pop(pop), .irq_take(take),
    .push_addr(pa), .irq_vector(vec), .cpu_boundary(bnd), .stack_full(full),
    .return_from_interrupt_exec(return_from_interrupt), .pc_next(pcn), .stack_top(top));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic apb(input logic w, input int unsigned r, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= OFS_EDGE + 8'(r * OFS_STEP);
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      errors++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input int unsigned r, input logic [7:0] e);
    apb(0, r, 8'h00);
    chk($sformatf("reg %0d", r), {24'h0, e}, rd);
  endtask
  task automatic done;
    tn++;
    $display("test %0d done", tn);
  endtask
  function automatic logic [12:0] vx(input int i);
    return 13'(4 + 4 * i);
  endfunction
  task automatic pulse_ret;
    @(posedge ref_clk);
    ret <= 1;
    @(posedge ref_clk);
    ret <= 0;
  endtask
  initial begin
    tick(2);
    arst_n <= 1;
    tick(3);
    for (int r = 0; r < NREG; r++) rchk(r, 8'h00);
    for (int r = 0; r < NREG; r++) begin
      apb(1, r, 8'hFF);
      rchk(r, msk[r]);
      apb(1, r, 8'h00);
    end
    apb(0, 9, 8'h00);
    chk("unmapped error", 1, er);
    done();
    run <= 1;
    @(posedge ref_clk);
    evt.adc <= 1;
    @(posedge ref_clk);
    evt <= '0;
    apb(1, R_CTL0, 8'h01);
    rchk(R_CTL2, 8'h10);
    chk("takes", 0, nt);
    apb(1, R_CTL0, 8'h00);
    apb(1, R_CTL2, 8'h33);
    tick(4);
    chk("takes", 0, nt);
    apb(1, R_CTL0, 8'h01);
    tick(4);
    chk("vector", vx(SRC_ADC), lv);
    rchk(R_CTL2, 8'h23);
    rchk(R_CTL0, 8'h00);
    apb(1, R_CTL0, 8'h01);
    tick(4);
    chk("vector", vx(SRC_TICK0), lv);
    @(posedge ref_clk);
    evt.adc <= 1;
    @(posedge ref_clk);
    evt <= '0;
    apb(1, R_CTL0, 8'h01);
    tick(4);
    chk("takes", 2, nt);
    pulse_ret();
    tick(4);
    chk("vector", vx(SRC_ADC), lv);
    done();
    pulse_ret();
    apb(1, R_IRQ_SERIAL_MEM_LVD_GROUP, 8'h01);
    apb(1, R_GRP, 8'h08);
    @(posedge ref_clk);
    evt.periph <= 4'b0001;
    @(posedge ref_clk);
    evt <= '0;
    tick(2);
    rchk(R_GRP, 8'h88);
    apb(1, R_CTL0, 8'h01);
    tick(4);
    chk("vector", vx(SRC_GRP4), lv);
    rchk(R_IRQ_SERIAL_MEM_LVD_GROUP, 8'h11);
    rchk(R_GRP, 8'h08);
    done();
    for (int m = 0; m < 4; m++) begin
      apb(1, R_EDGE, 8'(m * 5));
      apb(1, R_CTL0, 8'h00);
      apb(1, R_CTL2, 8'h00);
      ext0 <= 1;
      rf <= 1;
      tick(5);
      rchk(R_CTL0, {3'b0, m[0], 4'h0});
      rchk(R_CTL2, {m[0], 7'h0});
      apb(1, R_CTL0, 8'h00);
      apb(1, R_CTL2, 8'h00);
      ext0 <= 0;
      rf <= 0;
      tick(5);
      rchk(R_CTL0, {3'b0, m[1], 4'h0});
      rchk(R_CTL2, {m[1], 7'h0});
    end
    done();
    stop_test();
  end
endmodule
